// ### hdl/clkdiv_pkg.sv
/*
  constants and types shared by the clock divider and selection block:
  register map, field layout, fuse codes, sleep mode codes, delays.
  assumes a single 125 MHz source clock and an axi4-lite register bus.
*/
`default_nettype none

package clkdiv_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [31:0] REG_DIV_ADDR  = 32'h0000_0000;
  localparam logic [31:0] REG_STAT_ADDR = 32'h0000_0004;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ------------------------------------------------------------------
  // divide control layout
  // ------------------------------------------------------------------
  localparam int          FACTOR_W      = 7;
  localparam int          DIV_EN_BIT    = 7;
  localparam logic [7:0]  DIV_CTRL_RST  = 8'h00;
  localparam logic [7:0]  DIV_BASE      = 8'h81;  // 129
  localparam logic [7:0]  CNT_ONE       = 8'h01;

  // ------------------------------------------------------------------
  // status layout
  // ------------------------------------------------------------------
  localparam int          ST_RUN_BIT    = 0;
  localparam int          ST_BUSY_BIT   = 1;
  localparam int          ST_SRC_LSB    = 2;
  localparam int          ST_SUT_LSB    = 6;
  localparam int          ST_KIND_LSB   = 8;
  localparam int          ST_DIVON_BIT  = 11;

  // ------------------------------------------------------------------
  // fuses: one means unprogrammed, zero means programmed
  // ------------------------------------------------------------------
  localparam logic [3:0]  SRC_FUSE_DFLT = 4'h1;
  localparam logic [1:0]  SUT_FUSE_DFLT = 2'h2;
  localparam logic [1:0]  SUT_SHORT     = 2'h0;
  localparam logic [3:0]  SRC_XTAL_LO   = 4'ha;
  localparam logic [3:0]  SRC_LFX       = 4'h9;
  localparam logic [3:0]  SRC_RC_LO     = 4'h5;
  localparam logic [3:0]  SRC_INT_LO    = 4'h1;

  typedef enum logic [2:0] {
    KIND_XTAL, KIND_LF_XTAL, KIND_EXT_RC, KIND_INT_RC, KIND_EXT_CLK
  } src_kind_t;

  // ------------------------------------------------------------------
  // sleep modes and start-up counts
  // ------------------------------------------------------------------
  localparam logic [2:0]  SLP_IDLE      = 3'h0;
  localparam logic [2:0]  SLP_CONV      = 3'h1;
  localparam logic [2:0]  SLP_PDOWN     = 3'h2;
  localparam logic [2:0]  SLP_PSAVE     = 3'h3;
  localparam int          WDT_CNT_W     = 17;
  localparam int          WDT_SHORT_DFL = 4096;
  localparam int          WDT_LONG_DFL  = 65536;
  localparam int          WAKE_DFL      = 1024;
  localparam int          WAKE_CNT_W    = 16;

endpackage

`default_nettype wire

// ### hdl/clkdiv_ratio.sv
/*
  ratio divider: one-cycle enable pulse every (129 - factor) source
  cycles while on, every cycle while off.
  assumes the caller holds factor stable while on is high.
*/
`timescale 1ns/1ns
`default_nettype none

module clkdiv_ratio
(
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          div_on,
  input  wire logic [clkdiv_pkg::FACTOR_W-1:0] factor,
  output logic                               tick
);
  import clkdiv_pkg::*;

  typedef struct packed {
    logic                on;
    logic [FACTOR_W-1:0] factor;
    logic [7:0]          cnt;
    logic                tick;
  } div_state_t;

  div_state_t s_q;
  div_state_t s_d;
  logic [7:0] ratio;

  assign ratio = DIV_BASE - {1'b0, s_q.factor};
  assign tick  = s_q.tick;

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  // mode and factor change only at a period boundary, never mid-pulse
  always_comb
  begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (!s_q.on)
    begin
      s_d.tick   = 1'b1;
      s_d.cnt    = 8'h00;
      s_d.on     = div_on;
      s_d.factor = factor;
    end
    else if (s_q.cnt == ratio - CNT_ONE)
    begin
      s_d.tick   = 1'b1;
      s_d.cnt    = 8'h00;
      s_d.on     = div_on;
      s_d.factor = factor;
    end
    else
    begin
      s_d.cnt = s_q.cnt + CNT_ONE;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  logic [7:0] gap_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      gap_q <= 8'h00;
    else if (s_q.tick)
      gap_q <= CNT_ONE;
    else
      gap_q <= gap_q + CNT_ONE;
  end

  AST_DIV_RATIO: assert property (@(posedge clk) disable iff (rst)
    (s_q.tick && s_q.on && $past(s_q.on))
      |-> gap_q == $past(ratio))
    else $error("divided tick spacing differs from 129 minus factor");

  AST_UNDIV_EVERY: assert property (@(posedge clk) disable iff (rst)
    !s_q.on |=> s_q.tick)
    else $error("undivided clock missed a source cycle");

endmodule

`default_nettype wire

// ### hdl/system_clock_divider_select.sv
/*
  system clock divider, source selection and domain gating.
  assumes CLOCK is the selected source clock; domains are clocked by
  enable pulses; fuse, watchdog, crystal and wake pins are asynchronous.
*/
// The address map and the AXI4-Lite interface to the registers were decided locally.
// What this block does
// - enable bit divides core, peripheral, converter, flash clocks
// - divided rate is source over 129 minus factor
// - division ratios span 2 to 129
// - factor field frozen while division is enabled
// - enabling write captures factor from same access
// - disabling write discards factor from same access
// - enable bit writable at any time
// - four fuse bits select one of five sources
// - fuse one is unprogrammed, zero is programmed
// - wake from deep sleep counts source cycles
// - reset adds 4096 or 65536 watchdog cycles
// - core domain halts stop all core work
// - wake detection works with peripheral domain halted
// - flash domain runs together with core domain
// - async timer runs from crystal, even asleep
// - converter domain keeps running in noise mode
// - sleep mode decides which domains halt
// - delivered fuses are 0001 source and 10 start-up
`timescale 1ns/1ns
`default_nettype none

module system_clock_divider_select
#(
  parameter int WDT_SHORT_CYC = clkdiv_pkg::WDT_SHORT_DFL,
  parameter int WDT_LONG_CYC  = clkdiv_pkg::WDT_LONG_DFL,
  parameter int WAKE_CYC      = clkdiv_pkg::WAKE_DFL
)
(
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  input  wire logic [3:0]  SOURCE_SELECT_FUSES,
  input  wire logic [1:0]  STARTUP_TIME_FUSES,
  input  wire logic        WATCHDOG_OSC,
  input  wire logic        ASYNC_XTAL,
  input  wire logic        WAKE_EVENT,
  input  wire logic        SLEEP_REQ,
  input  wire logic [2:0]  SLEEP_MODE,
  output logic             CORE_CLOCK_EN,
  output logic             PERIPHERAL_CLOCK_EN,
  output logic             FLASH_IFC_CLOCK_EN,
  output logic             CONVERTER_CLOCK_EN,
  output logic             ASYNC_TIMER_CLOCK_EN,
  output logic             CORE_RUNNING,
  output logic [2:0]       SOURCE_KIND,
  input  wire logic [31:0] AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [31:0] ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY
);
  import clkdiv_pkg::*;

  typedef enum logic [1:0] {
    ST_RESET_DLY, ST_RUN, ST_SLEEP, ST_WAKE_DLY
  } state_t;

  typedef struct packed {
    state_t                state;
    logic [2:0]            mode;
    logic [WDT_CNT_W-1:0]  wdt_cnt;
    logic [WAKE_CNT_W-1:0] wake_cnt;
    logic [5:0]            fuse_s1;
    logic [5:0]            fuse_s2;
    logic [1:0]            fuse_arm;
    logic                  fuse_taken;
    logic [3:0]            src_fuse;
    logic [1:0]            sut_fuse;
    logic [2:0]            wdt_s;
    logic [2:0]            axt_s;
    logic [1:0]            wake_s;
    logic                  div_en;
    logic [FACTOR_W-1:0]   div_factor;
    logic                  aw_got;
    logic                  w_got;
    logic [31:0]           awaddr;
    logic [31:0]           wdata;
    logic                  wstrb0;
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  core_en;
    logic                  periph_en;
    logic                  flash_en;
    logic                  conv_en;
    logic                  async_en;
    logic [2:0]            kind;
    logic                  running;
  } ctl_state_t;

  ctl_state_t s_q;
  ctl_state_t s_d;
  logic       tick;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // four-bit source fuse code to source kind
  function automatic src_kind_t decode_src(input logic [3:0] f);
    if (f >= SRC_XTAL_LO)
      return KIND_XTAL;
    else if (f == SRC_LFX)
      return KIND_LF_XTAL;
    else if (f >= SRC_RC_LO)
      return KIND_EXT_RC;
    else if (f >= SRC_INT_LO)
      return KIND_INT_RC;
    else
      return KIND_EXT_CLK;
  endfunction

  // last watchdog count of the reset delay; used by logic and checks
  function automatic logic [WDT_CNT_W-1:0] wdt_last(input logic [1:0] startup_time_fuses);
    if (startup_time_fuses == SUT_SHORT)
      return WDT_CNT_W'(WDT_SHORT_CYC - 1);
    else
      return WDT_CNT_W'(WDT_LONG_CYC - 1);
  endfunction

  // ------------------------------------------------------------------
  // divider
  // ------------------------------------------------------------------
  clkdiv_ratio clkdiv_ratio_i
  (
    .clk    (CLOCK),
    .rst    (RESET),
    .div_on (s_q.div_en),
    .factor (s_q.div_factor),
    .tick   (tick)
  );

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    logic wdt_edge;
    logic axt_edge;
    logic in_sleep;
    logic aw_take;
    logic w_take;
    logic ar_take;
    wdt_edge = 1'b0;
    axt_edge = 1'b0;
    in_sleep = 1'b0;
    aw_take  = 1'b0;
    w_take   = 1'b0;
    ar_take  = 1'b0;
    s_d      = s_q;

    // pin synchronisers; first stage feeds only the second
    s_d.fuse_s1 = {STARTUP_TIME_FUSES, SOURCE_SELECT_FUSES};
    s_d.fuse_s2 = s_q.fuse_s1;
    s_d.wdt_s   = {s_q.wdt_s[1:0], WATCHDOG_OSC};
    s_d.axt_s   = {s_q.axt_s[1:0], ASYNC_XTAL};
    s_d.wake_s  = {s_q.wake_s[0], WAKE_EVENT};
    wdt_edge    = s_q.wdt_s[1] & ~s_q.wdt_s[2];
    axt_edge    = s_q.axt_s[1] & ~s_q.axt_s[2];

    // fuses are caught once, after the synchroniser has filled;
    // until then the delivered values stand
    s_d.fuse_arm = {s_q.fuse_arm[0], 1'b1};
    if (s_q.fuse_arm[1] && !s_q.fuse_taken)
    begin
      s_d.fuse_taken = 1'b1;
      s_d.src_fuse   = s_q.fuse_s2[3:0];
      s_d.sut_fuse   = s_q.fuse_s2[5:4];
    end
    s_d.kind = decode_src(s_q.src_fuse);

    // power state sequence
    unique case (s_q.state)
      ST_RESET_DLY:
      begin
        if (s_q.fuse_taken && wdt_edge)
        begin
          if (s_q.wdt_cnt == wdt_last(s_q.sut_fuse))
          begin
            s_d.state   = ST_RUN;
            s_d.wdt_cnt = '0;
          end
          else
            s_d.wdt_cnt = s_q.wdt_cnt + 1'b1;
        end
      end
      ST_RUN:
      begin
        if (SLEEP_REQ)
        begin
          s_d.state = ST_SLEEP;
          s_d.mode  = SLEEP_MODE;
        end
      end
      ST_SLEEP:
      begin
        // wake pin is synchronised only, so it works with domains off
        if (s_q.wake_s[1])
        begin
          if (s_q.mode == SLP_PDOWN || s_q.mode == SLP_PSAVE)
            s_d.state = ST_WAKE_DLY;
          else
            s_d.state = ST_RUN;
        end
      end
      ST_WAKE_DLY:
      begin
        if (s_q.wake_cnt == WAKE_CNT_W'(WAKE_CYC - 1))
        begin
          s_d.state    = ST_RUN;
          s_d.wake_cnt = '0;
        end
        else
          s_d.wake_cnt = s_q.wake_cnt + 1'b1;
      end
    endcase

    // running level gets its own flop so the pin is registered
    s_d.running = (s_d.state == ST_RUN);

    // domain enables: halted set depends on the sleep mode
    in_sleep      = (s_q.state == ST_SLEEP);
    s_d.core_en   = tick & (s_q.state == ST_RUN);
    s_d.flash_en  = tick & (s_q.state == ST_RUN);
    s_d.periph_en = tick & ((s_q.state == ST_RUN)
                    | (in_sleep & (s_q.mode == SLP_IDLE)));
    s_d.conv_en   = tick & ((s_q.state == ST_RUN)
                    | (in_sleep & (s_q.mode == SLP_IDLE
                                   | s_q.mode == SLP_CONV)));
    s_d.async_en  = axt_edge;

    // write channel: address and data taken in either order
    aw_take = s_q.awready & AWVALID;
    w_take  = s_q.wready & WVALID;
    if (aw_take)
    begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = AWADDR;
    end
    if (w_take)
    begin
      s_d.w_got  = 1'b1;
      s_d.wdata  = WDATA;
      s_d.wstrb0 = WSTRB[0];
    end
    if (s_q.bvalid && BREADY)
      s_d.bvalid = 1'b0;
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = RESP_OKAY;
      if (s_q.awaddr == REG_DIV_ADDR)
      begin
        if (s_q.wstrb0)
        begin
          // enable may be written any time; factor only from off
          s_d.div_en = s_q.wdata[DIV_EN_BIT];
          if (s_q.wdata[DIV_EN_BIT] && !s_q.div_en)
            s_d.div_factor = s_q.wdata[FACTOR_W-1:0];
        end
        // a clearing write leaves the held factor alone
      end
      else if (s_q.awaddr != REG_STAT_ADDR)
        s_d.bresp = RESP_SLVERR;
    end
    s_d.awready = ~s_d.aw_got & ~s_d.bvalid;
    s_d.wready  = ~s_d.w_got & ~s_d.bvalid;

    // read channel: answer in the cycle after the address is taken
    ar_take = s_q.arready & ARVALID;
    if (s_q.rvalid && RREADY)
      s_d.rvalid = 1'b0;
    if (ar_take)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      s_d.rdata  = '0;
      if (ARADDR == REG_DIV_ADDR)
        s_d.rdata[7:0] = {s_q.div_en, s_q.div_factor};
      else if (ARADDR == REG_STAT_ADDR)
      begin
        s_d.rdata[ST_RUN_BIT]  = (s_q.state == ST_RUN);
        s_d.rdata[ST_BUSY_BIT] = (s_q.state == ST_RESET_DLY)
                                 | (s_q.state == ST_WAKE_DLY);
        s_d.rdata[ST_SRC_LSB +: 4]  = s_q.src_fuse;
        s_d.rdata[ST_SUT_LSB +: 2]  = s_q.sut_fuse;
        s_d.rdata[ST_KIND_LSB +: 3] = s_q.kind;
        s_d.rdata[ST_DIVON_BIT]     = s_q.div_en;
      end
      else
        s_d.rresp = RESP_SLVERR;
    end
    s_d.arready = ~s_d.rvalid;
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  // delivered fuse values stand until the pins have been sampled
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      s_q            <= '0;
      s_q.state      <= ST_RESET_DLY;
      s_q.src_fuse   <= SRC_FUSE_DFLT;
      s_q.sut_fuse   <= SUT_FUSE_DFLT;
      s_q.div_en     <= DIV_CTRL_RST[DIV_EN_BIT];
      s_q.div_factor <= DIV_CTRL_RST[FACTOR_W-1:0];
    end
    else
      s_q <= s_d;
  end

  // outputs straight from the state register
  assign CORE_CLOCK_EN        = s_q.core_en;
  assign PERIPHERAL_CLOCK_EN  = s_q.periph_en;
  assign FLASH_IFC_CLOCK_EN   = s_q.flash_en;
  assign CONVERTER_CLOCK_EN   = s_q.conv_en;
  assign ASYNC_TIMER_CLOCK_EN = s_q.async_en;
  assign CORE_RUNNING         = s_q.running;
  assign SOURCE_KIND          = s_q.kind;
  assign AWREADY              = s_q.awready;
  assign WREADY               = s_q.wready;
  assign BVALID               = s_q.bvalid;
  assign BRESP                = s_q.bresp;
  assign ARREADY              = s_q.arready;
  assign RVALID               = s_q.rvalid;
  assign RDATA                = s_q.rdata;
  assign RRESP                = s_q.rresp;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  AST_FACTOR_LOCK: assert property (
    (s_q.div_en && $past(s_q.div_en)) |-> $stable(s_q.div_factor))
    else $error("factor changed while division enabled");

  AST_SET_CAPTURE: assert property (
    $rose(s_q.div_en) |-> s_q.div_factor == $past(s_q.wdata[FACTOR_W-1:0]))
    else $error("enabling write did not capture its factor");

  AST_CLEAR_KEEPS: assert property (
    $fell(s_q.div_en) |-> $stable(s_q.div_factor))
    else $error("disabling write altered the factor");

  AST_CORE_HALT: assert property (
    s_q.core_en |-> $past(s_q.state) == ST_RUN)
    else $error("core enable outside running state");

  AST_FLASH_CORE: assert property (
    s_q.flash_en == s_q.core_en)
    else $error("flash enable differs from core enable");

  AST_RESET_DELAY: assert property (
    ($past(s_q.state) == ST_RESET_DLY && s_q.state == ST_RUN)
      |-> $past(s_q.wdt_cnt) == wdt_last(s_q.sut_fuse))
    else $error("reset delay ended at the wrong watchdog count");

  AST_WAKE_DELAY: assert property (
    ($past(s_q.state) == ST_WAKE_DLY && s_q.state == ST_RUN)
      |-> $past(s_q.wake_cnt) == WAKE_CNT_W'(WAKE_CYC - 1))
    else $error("wake delay ended at the wrong source count");

  AST_ASYNC_FREE: assert property (
    (s_q.axt_s[1] && !s_q.axt_s[2]) |=> s_q.async_en)
    else $error("async timer edge not passed on");

  AST_CONV_NOISE: assert property (
    (s_q.state == ST_SLEEP && s_q.mode == SLP_CONV && tick)
      |=> s_q.conv_en && !s_q.periph_en)
    else $error("converter domain wrong in noise reduction sleep");

endmodule

`default_nettype wire

// ### dv/clock_source_model.sv
/*
  stand-ins for the watchdog oscillator and the 32 kHz timer crystal.
  assumes a 1 ns time unit; rates are scaled up to keep runs short.
*/
`timescale 1ns/1ns
`default_nettype none

module clock_source_model
#(
  parameter int WD_HALF = 23,
  parameter int XT_HALF = 2100  // above two slowest divided periods
)
(
  output logic wd_osc,
  output logic xtal
);
  // ------------------------------------------------------------------
  // oscillators
  // ------------------------------------------------------------------
  // both run free, also in sleep; phases unrelated to the source clock
  initial
  begin
    wd_osc = 1'b0;
    forever #WD_HALF wd_osc = ~wd_osc;  // times the reset delay
  end

  // keeps ticking while the system sleeps
  initial
  begin
    xtal = 1'b0;
    forever #XT_HALF xtal = ~xtal;
  end
endmodule

`default_nettype wire

// ### dv/tb_system_clock_divider_select.sv
/*
  self-checking bench for the clock divider and selection block.
  assumes the design package is compiled first; counts are shortened.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_system_clock_divider_select;
  import clkdiv_pkg::*;
  localparam int WAKE_N = 4;  // wake count shortened for the run
  logic        CLOCK, RESET, WD, XT, WAKE_EVENT, SLEEP_REQ;
  logic [3:0]  SOURCE_SELECT_FUSES, WSTRB;
  logic [1:0]  STARTUP_TIME_FUSES, BRESP, RRESP;
  logic [2:0]  SLEEP_MODE, SOURCE_KIND;
  logic        CORE_CLOCK_EN, PERIPHERAL_CLOCK_EN, FLASH_IFC_CLOCK_EN;
  logic        CONVERTER_CLOCK_EN, ASYNC_TIMER_CLOCK_EN, CORE_RUNNING;
  logic [31:0] AWADDR, WDATA, ARADDR, RDATA;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY;
  logic [34:0] rd_q[$];
  logic [1:0]  wr_q[$];
  logic [34:0] e;
  logic [1:0]  w;
  logic [6:0]  d;
  logic [4:0]  seen;
  int          fail_count, samples_checked;
  int          wn;
  logic [3:0]  fz[8] = '{4'hf, 4'ha, 4'h9, 4'h8, 4'h5, 4'h4, 4'h0, 4'h1};
  logic [2:0]  kd[8] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h3};
  logic [4:0]  dom[4] = '{5'h0e, 5'h0c, 5'h08, 5'h08};

  // ------------------------------------------------------------------
  // design and far side
  // ------------------------------------------------------------------
  system_clock_divider_select
  #(.WDT_SHORT_CYC(4), .WDT_LONG_CYC(8), .WAKE_CYC(WAKE_N))
  system_clock_divider_select_i
  (
    .CLOCK(CLOCK), .RESET(RESET), .SOURCE_SELECT_FUSES(SOURCE_SELECT_FUSES),
    .STARTUP_TIME_FUSES(STARTUP_TIME_FUSES), .WATCHDOG_OSC(WD),
    .ASYNC_XTAL(XT), .WAKE_EVENT(WAKE_EVENT), .SLEEP_REQ(SLEEP_REQ),
    .SLEEP_MODE(SLEEP_MODE), .CORE_CLOCK_EN(CORE_CLOCK_EN),
    .PERIPHERAL_CLOCK_EN(PERIPHERAL_CLOCK_EN),
    .FLASH_IFC_CLOCK_EN(FLASH_IFC_CLOCK_EN),
    .CONVERTER_CLOCK_EN(CONVERTER_CLOCK_EN),
    .ASYNC_TIMER_CLOCK_EN(ASYNC_TIMER_CLOCK_EN),
    .CORE_RUNNING(CORE_RUNNING), .SOURCE_KIND(SOURCE_KIND),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
    .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY)
  );

  clock_source_model clock_source_model_i (.wd_osc(WD), .xtal(XT));

  // 125 MHz source clock
  always #4 CLOCK = ~CLOCK;

  // ------------------------------------------------------------------
  // checking and reporting
  // ------------------------------------------------------------------
  task automatic check(input string nm, input logic [33:0] sv,
                       input logic [33:0] ev);
    samples_checked++;
    if (sv !== ev)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, ev, sv);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a wait that ran out of cycles ends the run at once
  task automatic tmo(input int n, input int lim);
    if (n >= lim)
    begin
      check("wait", 34'h0, 34'h1);
      final_report();
    end
  endtask

  // responses are paired with the oldest note at the handshake edge
  always @(posedge CLOCK)
  begin
    if (RVALID === 1'b1 && RREADY === 1'b1 && rd_q.size() > 0)
    begin
      e = rd_q.pop_front();
      check("read", {RRESP, e[34] ? RDATA : e[31:0]}, e[33:0]);
    end
    if (BVALID === 1'b1 && BREADY === 1'b1 && wr_q.size() > 0)
    begin
      w = wr_q.pop_front();
      check("bresp", {32'h0, BRESP}, {32'h0, w});
    end
    if (RESET === 1'b0)
      check("flash", {33'h0, FLASH_IFC_CLOCK_EN}, {33'h0, CORE_CLOCK_EN});
  end

  // ------------------------------------------------------------------
  // bus and measurement tasks
  // ------------------------------------------------------------------
  task automatic wr(input logic [31:0] a, input logic [31:0] v,
                    input logic [1:0] r);
    int n;
    wr_q.push_back(r);
    @(posedge CLOCK);
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    n = 0;
    do
    begin
      @(posedge CLOCK);
      if (AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WREADY === 1'b1) WVALID <= 1'b0;
      n++;
    end while (BVALID !== 1'b1 && n < 100);
    BREADY <= 1'b0;
    tmo(n, 100);
  endtask

  // m low: only the response code is compared, data is undefined
  task automatic rd(input logic [31:0] a, input logic m,
                    input logic [1:0] r, input logic [31:0] v);
    int n;
    rd_q.push_back({m, r, v});
    @(posedge CLOCK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    n = 0;
    do
    begin
      @(posedge CLOCK);
      if (ARREADY === 1'b1) ARVALID <= 1'b0;
      n++;
    end while (RVALID !== 1'b1 && n < 100);
    RREADY <= 1'b0;
    tmo(n, 100);
  endtask

  // the last of three gaps between core pulses, after a wait for the first pulse;
  // earlier ones may straddle the pending ratio switch
  task automatic meas(input int ev);
    int c;
    repeat (4)
    begin
      c = 0;
      do
      begin
        @(posedge CLOCK);
        c++;
      end while (CORE_CLOCK_EN !== 1'b1 && c < 300);
    end
    tmo(c, 300);
    check("period", 34'(c), 34'(ev));
  endtask

  // reset held 16 cycles, then watchdog rises counted until running
  task automatic do_reset(input logic [3:0] f, input logic [1:0] s,
                          input int nmin, input logic [2:0] k);
    int n;
    int cnt;
    logic wp;
    RESET <= 1'b1;
    SOURCE_SELECT_FUSES <= f;
    STARTUP_TIME_FUSES <= s;
    repeat (16) @(posedge CLOCK);
    RESET <= 1'b0;
    n = 0;
    cnt = 0;
    wp = WD;
    while (CORE_RUNNING !== 1'b1 && n < 1000)
    begin
      @(posedge CLOCK);
      cnt += int'(WD && !wp);
      wp = WD;
      n++;
    end
    tmo(n, 1000);
    check("delay", 34'(cnt >= nmin && cnt <= nmin + 2), 34'h1);
    check("kind", {31'h0, SOURCE_KIND}, {31'h0, k});
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    CLOCK = 1'b0;
    RESET = 1'b1;
    {SOURCE_SELECT_FUSES, STARTUP_TIME_FUSES} = {SRC_FUSE_DFLT, SUT_FUSE_DFLT};
    {WAKE_EVENT, SLEEP_REQ, SLEEP_MODE} = 5'h00;
    {AWADDR, WDATA, ARADDR} = '0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    WSTRB = 4'hf;
    fail_count = 0;
    samples_checked = 0;
    void'($urandom(65710));
    d = 7'($urandom % 128);
    do_reset(SRC_FUSE_DFLT, SUT_FUSE_DFLT, 8, 3'h3);
    foreach (fz[i]) do_reset(fz[i], SUT_SHORT, 4, kd[i]);
    rd(REG_DIV_ADDR, 1'b1, RESP_OKAY, 32'h0);
    rd(32'h0000_0010, 1'b0, RESP_SLVERR, 32'h0);
    wr(REG_STAT_ADDR, 32'hffff_ffff, RESP_OKAY);
    rd(REG_STAT_ADDR, 1'b1, RESP_OKAY, 32'h0000_0305);
    wr(REG_DIV_ADDR, {24'h0, 1'b1, d}, RESP_OKAY);
    rd(REG_DIV_ADDR, 1'b1, RESP_OKAY, {24'h0, 1'b1, d});
    meas(129 - int'(d));
    wr(REG_DIV_ADDR, {24'h0, 1'b1, d ^ 7'h55}, RESP_OKAY);
    rd(REG_DIV_ADDR, 1'b1, RESP_OKAY, {24'h0, 1'b1, d});
    wr(REG_DIV_ADDR, {24'h0, 1'b0, d ^ 7'h2a}, RESP_OKAY);
    rd(REG_DIV_ADDR, 1'b1, RESP_OKAY, {24'h0, 1'b0, d});
    WSTRB <= 4'he;
    wr(REG_DIV_ADDR, 32'h0000_00ff, RESP_OKAY);
    WSTRB <= 4'hf;
    rd(REG_DIV_ADDR, 1'b1, RESP_OKAY, {24'h0, 1'b0, d});
    meas(1);
    wr(REG_DIV_ADDR, 32'h0000_00ff, RESP_OKAY);
    meas(2);
    wr(REG_DIV_ADDR, 32'h0000_0000, RESP_OKAY);
    wr(REG_DIV_ADDR, 32'h0000_0080, RESP_OKAY);
    meas(129);
    wr(REG_DIV_ADDR, 32'h0000_0000, RESP_OKAY);
    // each sleep mode: which domains still pulse, then wake again
    for (int m = 0; m < 4; m++)
    begin
      @(posedge CLOCK);
      SLEEP_MODE <= 3'(m);
      SLEEP_REQ <= 1'b1;
      @(posedge CLOCK);
      SLEEP_REQ <= 1'b0;
      repeat (4) @(posedge CLOCK);
      seen = 5'h00;
      repeat (600)
      begin
        @(posedge CLOCK);
        seen |= {CORE_RUNNING, ASYNC_TIMER_CLOCK_EN, CONVERTER_CLOCK_EN,
                 PERIPHERAL_CLOCK_EN, CORE_CLOCK_EN};
      end
      check("domains", {29'h0, seen}, {29'h0, dom[m]});
      WAKE_EVENT <= 1'b1;
      wn = 0;
      do
      begin
        @(posedge CLOCK);
        wn++;
      end while (CORE_RUNNING !== 1'b1 && wn < 100);
      tmo(wn, 100);
      // two sync flops, one state edge, then the wake count if deep sleep
      check("wake", 34'(wn), 34'(m >= 2 ? 4 + WAKE_N : 4));
      WAKE_EVENT <= 1'b0;
      repeat (4) @(posedge CLOCK);
    end
    final_report();
  end
endmodule

`default_nettype wire
